// *** rtl/breaker_mon_cfg.svh ***
// Offsets, field positions, reset values and timing for the breaker monitor.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef BREAKER_MON_CFG_SVH
`define BREAKER_MON_CFG_SVH

`define CLK_HZ 100000000
`define TICK_HZ 100
`define TICK_CYCLES (`CLK_HZ / `TICK_HZ)
`define CLOSED_HOLD_S 5
`define CLOSED_HOLD_TICKS (`CLOSED_HOLD_S * `TICK_HZ)

`define ADDR_CTRL 8'h00
`define ADDR_OPEN_TIME 8'h04
`define ADDR_ATTEMPTS 8'h08
`define ADDR_SYNC_DELAY 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_IRQ_CLEAR 8'h14
`define ADDR_IRQ_ENABLE 8'h18
`define ADDR_STATE 8'h1c

`define CTRL_BRK_EN 0
`define CTRL_BRK_CLASS 1
`define CTRL_BRK_LOCKABLE 2
`define CTRL_SYNC_EN 3
`define CTRL_SYNC_SELF_ACK 4
`define CTRL_SYNC_LOCKABLE 5
`define CTRL_ACK 8
`define CTRL_RESET 8'h0b

`define OPEN_TIME_MIN 16'd10
`define OPEN_TIME_MAX 16'd500
`define OPEN_TIME_RESET 16'd200
`define ATTEMPTS_MIN 4'd1
`define ATTEMPTS_MAX 4'd10
`define ATTEMPTS_RESET 4'd5
`define SYNC_DELAY_MIN 10'd3
`define SYNC_DELAY_MAX 10'd999
`define SYNC_DELAY_RESET 10'd60

`define ST_FAIL_OPEN 0
`define ST_FAIL_CLOSE 1
`define ST_SYNC_TIMEOUT 2

`endif

// *** rtl/breaker_mon_pkg.sv ***
// Types for the breaker supervision monitor.
// No dependencies.
package breaker_mon_pkg;
  typedef enum logic {
    class_a,
    class_b
  } alarm_class_e;
  typedef enum logic [1:0] {
    open_idle,
    open_timing,
    open_done
  } open_state_e;
endpackage : breaker_mon_pkg

// *** rtl/breaker_supervision_monitor.sv ***
// Breaker A supervision: fail-to-open, fail-to-close, sync timeout.
// Assumes AXI4-Lite master on i_sys_clk; pin inputs are asynchronous.
`include "breaker_mon_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module breaker_supervision_monitor
  import breaker_mon_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_breaker_feedback_input,
  input wire logic i_open_sequence,
  input wire logic i_close_breaker_command,
  input wire logic i_sync_request,
  input wire logic i_sync_done,
  input wire logic i_monitor_lock,
  input wire logic i_ext_ack,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_fail_to_open_alarm,
  output logic o_fail_to_close_alarm,
  output logic o_sync_timeout_alarm,
  output logic o_breaker_alarm_class,
  output logic o_irq
);
  // Three-stage pin synchronisers; change accepted when stages 2 and 3 agree
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1;
  logic [NPIN-1:0] s2;
  logic [NPIN-1:0] s3;
  logic [NPIN-1:0] pin;
  assign pin_raw = {i_ext_ack, i_monitor_lock, i_sync_done, i_sync_request,
    i_close_breaker_command, i_open_sequence, i_breaker_feedback_input};
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
          pin[g] <= 1'b0;
        end else if (i_clk_en) begin
          s1[g] <= pin_raw[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            pin[g] <= s3[g];
          end
        end
      end
    end
  endgenerate
  logic fb;
  logic open_seq;
  logic close_cmd;
  logic sync_req;
  logic sync_done;
  logic lock;
  logic ext_ack;
  assign {ext_ack, lock, sync_done, sync_req, close_cmd, open_seq, fb} = pin;

  // Registers
  logic [5:0] ctrl;
  logic [15:0] open_time;
  logic [3:0] max_attempts;
  logic [9:0] sync_delay;
  logic [2:0] status;
  logic [2:0] irq_en;
  logic [2:0] irq_clr;
  logic ack_pulse;
  logic brk_active;
  logic sync_active;

  assign brk_active = ctrl[`CTRL_BRK_EN] &
    ~(ctrl[`CTRL_BRK_LOCKABLE] & lock);
  assign sync_active = ctrl[`CTRL_SYNC_EN] &
    ~(ctrl[`CTRL_SYNC_LOCKABLE] & lock);

  logic [31:0] tick_cnt;
  logic tick;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else if (i_clk_en) begin
      tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0 :
        tick_cnt + 32'h1;
    end
  end

  // Open supervision
  open_state_e open_state;
  logic [15:0] open_cnt;
  logic open_prev;
  logic fail_open_evt;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      open_state <= open_idle;
      open_cnt <= 16'h0;
      open_prev <= 1'b0;
      fail_open_evt <= 1'b0;
    end else if (i_clk_en) begin
      open_prev <= open_seq;
      fail_open_evt <= 1'b0;
      case (open_state)
        open_idle: begin
          if (open_seq && !open_prev && brk_active) begin
            open_state <= open_timing;
            open_cnt <= 16'h0;
          end
        end
        open_timing: begin
          if (!brk_active || fb) begin
            open_state <= open_idle;
          end else if (tick) begin
            open_cnt <= open_cnt + 16'h1;
            if (open_cnt + 16'h1 >= open_time) begin
              fail_open_evt <= 1'b1;
              open_state <= open_done;
            end
          end
        end
        default: begin
          if (!open_seq) begin
            open_state <= open_idle;
          end
        end
      endcase
    end
  end

  // Close attempts and closed-hold reset
  logic [3:0] attempts;
  logic close_prev;
  logic [9:0] closed_ticks;
  logic fail_close_evt;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      attempts <= 4'h0;
      close_prev <= 1'b0;
      closed_ticks <= 10'h0;
      fail_close_evt <= 1'b0;
    end else if (i_clk_en) begin
      close_prev <= close_cmd;
      fail_close_evt <= 1'b0;
      if (fb) begin
        closed_ticks <= 10'h0;
      end else if (tick && closed_ticks != 10'(`CLOSED_HOLD_TICKS)) begin
        closed_ticks <= closed_ticks + 10'h1;
      end
      if (closed_ticks == 10'(`CLOSED_HOLD_TICKS)) begin
        attempts <= 4'h0;
      end else if (close_cmd && !close_prev && brk_active) begin
        attempts <= attempts + 4'h1;
        if (attempts + 4'h1 == max_attempts) begin
          fail_close_evt <= 1'b1;
        end
      end
    end
  end

  // Sync supervision
  logic [9:0] sync_sec;
  logic [6:0] sync_sub;
  logic sync_fault;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_sec <= 10'h0;
      sync_sub <= 7'h0;
      sync_fault <= 1'b0;
    end else if (i_clk_en) begin
      if (!sync_active || !sync_req || sync_done) begin
        sync_sec <= 10'h0;
        sync_sub <= 7'h0;
        sync_fault <= 1'b0;
      end else if (tick && !sync_fault) begin
        sync_sub <= (sync_sub == 7'(`TICK_HZ - 1)) ? 7'h0 : sync_sub + 7'h1;
        if (sync_sub == 7'(`TICK_HZ - 1)) begin
          sync_sec <= sync_sec + 10'h1;
          if (sync_sec + 10'h1 >= sync_delay) begin
            sync_fault <= 1'b1;
          end
        end
      end
    end
  end

  // Alarm latches
  logic ack;
  assign ack = ack_pulse | ext_ack;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fail_to_open_alarm <= 1'b0;
      o_fail_to_close_alarm <= 1'b0;
      o_sync_timeout_alarm <= 1'b0;
      o_breaker_alarm_class <= 1'b1;
    end else if (i_clk_en) begin
      o_breaker_alarm_class <= ctrl[`CTRL_BRK_CLASS];
      if (fail_open_evt) begin
        o_fail_to_open_alarm <= 1'b1;
      end else if (ack) begin
        o_fail_to_open_alarm <= 1'b0;
      end
      if (fail_close_evt) begin
        o_fail_to_close_alarm <= 1'b1;
      end else if (ack) begin
        o_fail_to_close_alarm <= 1'b0;
      end
      if (sync_fault) begin
        o_sync_timeout_alarm <= 1'b1;
      end else if (ctrl[`CTRL_SYNC_SELF_ACK]) begin
        o_sync_timeout_alarm <= 1'b0;
      end else if (ack) begin
        o_sync_timeout_alarm <= 1'b0;
      end
    end
  end

  // Sticky status and interrupt
  logic [2:0] evt;
  assign evt = {sync_fault & ~o_sync_timeout_alarm, fail_close_evt,
    fail_open_evt};
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      status <= 3'h0;
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      status <= evt | (status & ~irq_clr);
      o_irq <= |(status & irq_en);
    end
  end

  // AXI4-Lite write
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  assign do_write = aw_held && w_held && !o_bvalid;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'b00;
    end else if (i_clk_en) begin
      o_awready <= !aw_held && !(o_awready && i_awvalid);
      o_wready <= !w_held && !(o_wready && i_wvalid);
      if (o_awready && i_awvalid) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (aw_addr > `ADDR_STATE) ? 2'b10 : 2'b00;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl <= 6'(`CTRL_RESET);
      open_time <= `OPEN_TIME_RESET;
      max_attempts <= `ATTEMPTS_RESET;
      sync_delay <= `SYNC_DELAY_RESET;
      irq_en <= 3'h0;
      irq_clr <= 3'h0;
      ack_pulse <= 1'b0;
    end else if (i_clk_en) begin
      irq_clr <= 3'h0;
      ack_pulse <= 1'b0;
      // Out-of-range settings are ignored, keeping the old value
      if (do_write && w_strb[0]) begin
        if (aw_addr == `ADDR_CTRL) begin
          ctrl <= w_data[5:0];
          ack_pulse <= w_strb[1] & w_data[`CTRL_ACK];
        end else if (aw_addr == `ADDR_OPEN_TIME && w_strb[1]) begin
          if (w_data[15:0] >= `OPEN_TIME_MIN &&
              w_data[15:0] <= `OPEN_TIME_MAX) begin
            open_time <= w_data[15:0];
          end
        end else if (aw_addr == `ADDR_ATTEMPTS) begin
          if (w_data[7:0] >= 8'(`ATTEMPTS_MIN) &&
              w_data[7:0] <= 8'(`ATTEMPTS_MAX)) begin
            max_attempts <= w_data[3:0];
          end
        end else if (aw_addr == `ADDR_SYNC_DELAY && w_strb[1]) begin
          if (w_data[15:0] >= 16'(`SYNC_DELAY_MIN) &&
              w_data[15:0] <= 16'(`SYNC_DELAY_MAX)) begin
            sync_delay <= w_data[9:0];
          end
        end else if (aw_addr == `ADDR_IRQ_CLEAR) begin
          irq_clr <= w_data[2:0];
        end else if (aw_addr == `ADDR_IRQ_ENABLE) begin
          irq_en <= w_data[2:0];
        end
      end
    end
  end

  // AXI4-Lite read
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= 2'b00;
    end else if (i_clk_en) begin
      o_arready <= !o_rvalid && !(o_arready && i_arvalid);
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rresp <= 2'b00;
        if (i_araddr == `ADDR_CTRL) begin
          o_rdata <= {26'h0, ctrl[5:0]};
        end else if (i_araddr == `ADDR_OPEN_TIME) begin
          o_rdata <= {16'h0, open_time};
        end else if (i_araddr == `ADDR_ATTEMPTS) begin
          o_rdata <= {28'h0, max_attempts};
        end else if (i_araddr == `ADDR_SYNC_DELAY) begin
          o_rdata <= {22'h0, sync_delay};
        end else if (i_araddr == `ADDR_STATUS) begin
          o_rdata <= {29'h0, status};
        end else if (i_araddr == `ADDR_IRQ_ENABLE) begin
          o_rdata <= {29'h0, irq_en};
        end else if (i_araddr == `ADDR_STATE) begin
          o_rdata <= {22'h0, o_sync_timeout_alarm, o_fail_to_close_alarm,
            o_fail_to_open_alarm, open_state == open_timing, attempts,
            1'b0, fb};
        end else if (i_araddr == `ADDR_IRQ_CLEAR) begin
          o_rdata <= 32'h0;
        end else begin
          o_rdata <= 32'h0;
          o_rresp <= 2'b10;
        end
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // Assertions
  a_clear_after_hold: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) i_clk_en &&
    closed_ticks == 10'(`CLOSED_HOLD_TICKS) |=> attempts == 4'h0)
    else $error("attempt counter not cleared after hold");
  a_close_limit: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) fail_close_evt |-> attempts == max_attempts)
    else $error("fail-to-close raised off limit");
  a_close_flag: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) fail_close_evt && i_clk_en |=>
    o_fail_to_close_alarm)
    else $error("fail-to-close flag missing");
  a_open_flag: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) fail_open_evt && i_clk_en |=>
    o_fail_to_open_alarm)
    else $error("fail-to-open flag missing");
  a_open_expiry: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) $rose(fail_open_evt) |-> open_cnt >= open_time)
    else $error("fail-to-open before expiry");
  a_lock_blocks: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) lock && ctrl[`CTRL_BRK_LOCKABLE] && i_clk_en
    |=> open_state != open_timing)
    else $error("open timing while locked");
  a_sync_delay: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) $rose(sync_fault) |-> sync_sec >= sync_delay)
    else $error("sync timeout early");
  a_sync_latched: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) o_sync_timeout_alarm && !sync_fault &&
    !ctrl[`CTRL_SYNC_SELF_ACK] && !ack && i_clk_en |=> o_sync_timeout_alarm)
    else $error("sync alarm dropped without ack");
  a_sync_self_ack: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) !sync_fault && ctrl[`CTRL_SYNC_SELF_ACK] &&
    i_clk_en |=> !o_sync_timeout_alarm)
    else $error("self-ack did not clear");
endmodule : breaker_supervision_monitor
`default_nettype wire

// *** verification/breaker_model.sv ***
// Behavioural breaker A: command levels in, feedback contact out.
// Assumes commands change just after rising edges of i_sys_clk.
`timescale 1ns/100ps
`default_nettype none
module breaker_model (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_open_cmd,
  input wire logic i_close_cmd,
  input wire logic i_stuck,
  input wire logic [7:0] i_delay,
  output logic o_feedback
);
  logic open_q;
  logic close_q;
  logic moving;
  logic target;
  logic [7:0] cnt;
  // Feedback high means open; welded contacts ignore every command
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      open_q <= 1'b0;
      close_q <= 1'b0;
      moving <= 1'b0;
      target <= 1'b0;
      cnt <= 8'h00;
      o_feedback <= 1'b0;
    end else begin
      open_q <= i_open_cmd;
      close_q <= i_close_cmd;
      if (!i_stuck && i_open_cmd && !open_q) begin
        moving <= 1'b1;
        target <= 1'b1;
        cnt <= i_delay;
      end else if (!i_stuck && i_close_cmd && !close_q) begin
        moving <= 1'b1;
        target <= 1'b0;
        cnt <= i_delay;
      end else if (moving) begin
        if (cnt == 8'h00) begin
          o_feedback <= target;
          moving <= 1'b0;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
endmodule : breaker_model
`default_nettype wire

// *** verification/test_breaker_supervision_monitor.sv ***
// Bench for the breaker monitor: AXI4-Lite tasks and pin sequences.
// Assumes a 10-cycle tick so every timer spans a short run.
`include "breaker_mon_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module test_breaker_supervision_monitor;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic open_seq = 1'b0, close_cmd = 1'b0, sync_req = 1'b0;
  logic sync_done = 1'b0, mon_lock = 1'b0, ext_ack = 1'b0;
  logic stuck = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, feedback;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rdat;
  logic [1:0] rrsp;
  logic fail_open, fail_close, sync_alarm, alarm_class, irq;
  int err_count = 0;
  int tests_run = 0;

  breaker_supervision_monitor #(
    .TICK_CYCLES(10)
  ) u_breaker_supervision_monitor (
    .i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_clk_en(clk_en),
    .i_breaker_feedback_input(feedback), .i_open_sequence(open_seq),
    .i_close_breaker_command(close_cmd), .i_sync_request(sync_req),
    .i_sync_done(sync_done), .i_monitor_lock(mon_lock), .i_ext_ack(ext_ack),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_fail_to_open_alarm(fail_open), .o_fail_to_close_alarm(fail_close),
    .o_sync_timeout_alarm(sync_alarm), .o_breaker_alarm_class(alarm_class),
    .o_irq(irq));

  breaker_model u_breaker_model (
    .i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_open_cmd(open_seq),
    .i_close_cmd(close_cmd), .i_stuck(stuck), .i_delay(8'd20),
    .o_feedback(feedback));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic summarize;
    $display("errors %0d comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic flag_check(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask : flag_check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge sys_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check({30'h0, bresp}, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdat = rdata;
    rrsp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(rdat, exp);
    check({30'h0, rrsp}, 32'h0);
  endtask : rd_check

  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp);
    wr(a, d, 4'hf);
    rd_check(a, exp);
  endtask : wr_rd

  function automatic logic alarm(input int k);
    case (k)
      0: return fail_open;
      1: return fail_close;
      default: return sync_alarm;
    endcase
  endfunction : alarm

  task automatic wait_alarm(input int k, input int n, input logic exp);
    for (int i = 0; i < n && alarm(k) !== exp; i++) @(posedge sys_clk);
    flag_check(alarm(k), exp);
  endtask : wait_alarm

  // Pin index: 0 open sequence, 1 close command, else external ack
  task automatic set_pin(input int k, input logic v);
    case (k)
      0: open_seq <= v;
      1: close_cmd <= v;
      default: ext_ack <= v;
    endcase
  endtask : set_pin

  task automatic pulse(input int k, input int n);
    @(posedge sys_clk);
    set_pin(k, 1'b1);
    tick(n);
    set_pin(k, 1'b0);
    tick(40);
  endtask : pulse

  initial begin
    #500000;
    err_count++;
    summarize();
  end

  initial begin
    tick(4);
    reset_n <= 1'b1;
    rd_check(`ADDR_CTRL, {24'h0, `CTRL_RESET});
    rd_check(`ADDR_OPEN_TIME, {16'h0, `OPEN_TIME_RESET});
    rd_check(`ADDR_ATTEMPTS, {28'h0, `ATTEMPTS_RESET});
    rd_check(`ADDR_SYNC_DELAY, {22'h0, `SYNC_DELAY_RESET});
    rd(8'h20);
    check({30'h0, rrsp}, 32'h2);
    flag_check(alarm_class, 1'b1);
    wr_rd(`ADDR_OPEN_TIME, 32'd9, 32'd200);
    wr_rd(`ADDR_OPEN_TIME, 32'd501, 32'd200);
    wr_rd(`ADDR_OPEN_TIME, 32'd10, 32'd10);
    wr(`ADDR_IRQ_ENABLE, 32'h7, 4'hf);
    // Welded contacts: breaker never reports open
    stuck <= 1'b1;
    @(posedge sys_clk);
    open_seq <= 1'b1;
    tick(85);
    flag_check(fail_open, 1'b0);
    wait_alarm(0, 60, 1'b1);
    open_seq <= 1'b0;
    rd_check(`ADDR_STATUS, 32'h1);
    flag_check(irq, 1'b1);
    wr(`ADDR_CTRL, 32'h10b, 4'h3);
    wait_alarm(0, 8, 1'b0);
    wr(`ADDR_IRQ_CLEAR, 32'h1, 4'hf);
    tick(3);
    flag_check(irq, 1'b0);
    wr(`ADDR_CTRL, 32'h0a, 4'hf);
    pulse(0, 200);
    flag_check(fail_open, 1'b0);
    wr(`ADDR_CTRL, 32'h0f, 4'hf);
    mon_lock <= 1'b1;
    pulse(0, 200);
    flag_check(fail_open, 1'b0);
    mon_lock <= 1'b0;
    pulse(0, 200);
    flag_check(fail_open, 1'b1);
    pulse(2, 8);
    flag_check(fail_open, 1'b0);
    wr(`ADDR_CTRL, 32'h0b, 4'hf);
    stuck <= 1'b0;
    pulse(0, 200);
    flag_check(fail_open, 1'b0);
    wr_rd(`ADDR_ATTEMPTS, 32'd11, 32'd5);
    wr_rd(`ADDR_ATTEMPTS, 32'd0, 32'd5);
    wr_rd(`ADDR_ATTEMPTS, 32'd2, 32'd2);
    pulse(1, 10);
    rd(`ADDR_STATE);
    check({28'h0, rdat[5:2]}, 32'h1);
    // Breaker closed over 5 s wipes the attempt count
    tick(5100);
    rd(`ADDR_STATE);
    check({28'h0, rdat[5:2]}, 32'h0);
    pulse(0, 200);
    stuck <= 1'b1;
    pulse(1, 10);
    flag_check(fail_close, 1'b0);
    pulse(1, 10);
    wait_alarm(1, 20, 1'b1);
    // Fail-open from the lock test is still sticky
    rd_check(`ADDR_STATUS, 32'h3);
    pulse(2, 8);
    flag_check(fail_close, 1'b0);
    // Frozen clock enable: an attempt meanwhile leaves no trace
    clk_en <= 1'b0;
    pulse(1, 10);
    clk_en <= 1'b1;
    tick(10);
    rd(`ADDR_STATE);
    check({28'h0, rdat[5:2]}, 32'h2);
    wr_rd(`ADDR_SYNC_DELAY, 32'd2, 32'd60);
    wr_rd(`ADDR_SYNC_DELAY, 32'd1000, 32'd60);
    wr_rd(`ADDR_SYNC_DELAY, 32'd3, 32'd3);
    sync_req <= 1'b1;
    tick(2900);
    flag_check(sync_alarm, 1'b0);
    wait_alarm(2, 300, 1'b1);
    rd_check(`ADDR_STATUS, 32'h7);
    sync_req <= 1'b0;
    tick(20);
    flag_check(sync_alarm, 1'b1);
    pulse(2, 8);
    flag_check(sync_alarm, 1'b0);
    wr(`ADDR_CTRL, 32'h1b, 4'hf);
    sync_req <= 1'b1;
    wait_alarm(2, 3200, 1'b1);
    sync_done <= 1'b1;
    wait_alarm(2, 20, 1'b0);
    sync_done <= 1'b0;
    sync_req <= 1'b0;
    wr(`ADDR_CTRL, 32'h03, 4'hf);
    sync_req <= 1'b1;
    tick(3200);
    flag_check(sync_alarm, 1'b0);
    sync_req <= 1'b0;
    // Sync monitor lockable: held off while the lock flag is set
    wr(`ADDR_CTRL, 32'h2b, 4'hf);
    mon_lock <= 1'b1;
    sync_req <= 1'b1;
    tick(3200);
    flag_check(sync_alarm, 1'b0);
    mon_lock <= 1'b0;
    wait_alarm(2, 3200, 1'b1);
    sync_req <= 1'b0;
    pulse(2, 8);
    flag_check(sync_alarm, 1'b0);
    wr(`ADDR_CTRL, 32'h09, 4'hf);
    tick(2);
    flag_check(alarm_class, 1'b0);
    wr(`ADDR_IRQ_ENABLE, 32'h0, 4'hf);
    tick(3);
    flag_check(irq, 1'b0);
    wr(`ADDR_IRQ_ENABLE, 32'h6, 4'hf);
    tick(3);
    flag_check(irq, 1'b1);
    wr(`ADDR_IRQ_CLEAR, 32'h6, 4'hf);
    tick(3);
    flag_check(irq, 1'b0);
    // Clear touches only the written bits
    rd_check(`ADDR_STATUS, 32'h1);
    rd_check(`ADDR_IRQ_CLEAR, 32'h0);
    summarize();
  end
endmodule : test_breaker_supervision_monitor
`default_nettype wire
